// File: common/pin_change_pkg.sv
// Constants, types and register map of the pin change detector.
// Assumes an 8-bit register port and the 200 MHz system clock.
//
// Contract
// R1: Edges still set flags while the module interrupt enable is clear.
// R2: Each pin has its own rising and falling detector, each separately armed.
// R3: With both enables set a pin responds to either direction.
// R4: An armed edge sets the pin flag and requests an interrupt if enabled.
// R5: The summary flag is the OR of all per-pin flags.
// R6: Writing zero clears a flag, but a coinciding armed edge leaves it set.
// R7: Software should clear flags by ANDing with the inverse of seen bits.
// R8: An armed edge wakes the device only when the interrupt enable is set.
// R9: Edges seen during sleep are in the flags before the first instruction.
// R10: Port A rising enables use bits 5..0; bits 7..6 read zero.
// R11: Port A falling enables use bits 5..0; bits 7..6 read zero.
// R12: Port A flags 5..0 set on armed rising or falling edges only; the code also sets them when ones are written to the flag register.
// R13: Port B rising enables use bits 7..4 on the large variant.
// R14: Port B falling enables use bits 7..4; bits 3..0 read zero.
// R15: Port B flags 7..4 set on armed edges; bits 3..0 read zero.
// R16: Port C has all three registers, bits 7..6 only on the large variant.
// R17: Pins are synchronised and compared with prior samples; all bits reset zero.

package pin_change_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;
   localparam int PORTS = 3;
   localparam logic [3:0] RISE_OFS [PORTS] = '{4'h0, 4'h3, 4'h6};
   localparam logic [3:0] FALL_OFS [PORTS] = '{4'h1, 4'h4, 4'h7};
   localparam logic [3:0] FLAG_OFS [PORTS] = '{4'h2, 4'h5, 4'h8};
   localparam logic [3:0] CTRL_OFS = 4'h9;
   localparam logic [3:0] STATUS_OFS = 4'ha;

   // ------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] PORT_A_MASK = 8'h3f;
   localparam logic [7:0] PORT_B_MASK = 8'hf0;
   localparam logic [7:0] PORT_C_MASK_LARGE = 8'hff;
   localparam logic [7:0] PORT_C_MASK_SMALL = 8'h3f;
   localparam logic [7:0] ABSENT_MASK = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int IRQ_EN_BIT = 0;
   localparam int SUMMARY_BIT = 0;
   localparam int SLEEP_BIT = 1;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic {
      SETTLING = 1'b0,
      TRACKING = 1'b1
   } track_state_t;

endpackage

// File: common/port_bank_if.sv
// Carrier between the register decode and one port's change bank.
// Assumes one instance per port, all on ref_clk.

interface port_bank_if;
   logic wr_rise;
   logic wr_fall;
   logic wr_flags;
   logic [7:0] wdata;
   logic [7:0] rise_en;
   logic [7:0] fall_en;
   logic [7:0] flags;
   logic [7:0] hit;

   modport bank (
      input wr_rise, wr_fall, wr_flags, wdata,
      output rise_en, fall_en, flags, hit
   );

   modport ctrl (
      output wr_rise, wr_fall, wr_flags, wdata,
      input rise_en, fall_en, flags, hit
   );
endinterface

// File: core/pin_sync_edge.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes asynchronous pins and a single ref_clk domain.

module pin_sync_edge #(
   parameter int W = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] rise_ev,
   output logic [W-1:0] fall_ev
);

   // ------------------------------------------------------------
   // Synchroniser and settled value
   // ------------------------------------------------------------
   logic [W-1:0] sync1;
   logic [W-1:0] sync2;
   logic [W-1:0] sync3;
   logic [W-1:0] stable;
   logic [W-1:0] next_stable;
   pin_change_pkg::track_state_t state;
   logic [1:0] fill;
   wire filled = &fill;
   wire agree_all = (sync2 == sync3);
   wire tracking = (state == pin_change_pkg::TRACKING);

   // A bit moves only once the second and third stages agree.
   assign next_stable = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & stable); // [R17]
   assign rise_ev = tracking ? (next_stable & ~stable) : '0; // [R17]
   assign fall_ev = tracking ? (~next_stable & stable) : '0; // [R17]

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // The first settled sample after reset is taken without an edge.
   // Settling waits until all three stages hold real pin samples, so a pin held high through reset makes no edge.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stable <= '0;
         fill <= 2'h0;
         state <= pin_change_pkg::SETTLING;
      end else begin
         case (state)
            pin_change_pkg::SETTLING: begin
               if (filled && agree_all) begin
                  stable <= sync3;
                  state <= pin_change_pkg::TRACKING;
               end else if (!filled) begin
                  fill <= fill + 2'h1;
               end
            end
            pin_change_pkg::TRACKING: begin
               stable <= next_stable;
            end
            default: begin
               state <= pin_change_pkg::SETTLING;
            end
         endcase
      end
   end

endmodule

// File: core/port_change_bank.sv
// Enable and flag registers of one port with the armed-edge match.
// Assumes edge pulses from pin_sync_edge on the same clock.

module port_change_bank #(
   parameter logic [7:0] MASK = 8'hff
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] rise_ev,
   input wire logic [7:0] fall_ev,
   port_bank_if.bank bus
);

   // ------------------------------------------------------------
   // Armed-edge match and flag update
   // ------------------------------------------------------------
   logic [7:0] next_flags;

   // Either enable arms its own detector; both arm both directions.
   assign bus.hit = ((rise_ev & bus.rise_en) | (fall_ev & bus.fall_en)) & MASK; // [R2] [R3] [R12] [R15]
   // Hardware set wins over a software write in the same cycle.
   assign next_flags = ((bus.wr_flags ? bus.wdata : bus.flags) | bus.hit) & MASK; // [R4] [R6]

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bus.rise_en <= pin_change_pkg::REG_RESET; // [R17]
         bus.fall_en <= pin_change_pkg::REG_RESET;
         bus.flags <= pin_change_pkg::REG_RESET;
      end else begin
         if (bus.wr_rise) begin
            bus.rise_en <= bus.wdata & MASK; // [R10] [R13]
         end
         if (bus.wr_fall) begin
            bus.fall_en <= bus.wdata & MASK; // [R11] [R14]
         end
         bus.flags <= next_flags; // [R1]
      end
   end

endmodule

// File: core/pin_change_interrupt_detector.sv
// Top of the pin change detector: register port, three port banks,
// summary flag, interrupt request and wake request.
// Assumes software drives one-cycle strobes on ref_clk and that the
// pins are asynchronous to it.
//
// The placing of the registers and the strobed register port were decided locally.

module pin_change_interrupt_detector #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [7:0] rd_data,
   input wire logic [7:0] port_a_pin,
   input wire logic [7:0] port_b_pin,
   input wire logic [7:0] port_c_pin,
   input wire logic sleep_mode,
   output logic change_summary_flag,
   output logic change_irq,
   output logic wake_req
);

   // ------------------------------------------------------------
   // Elaboration checks and port masks
   // ------------------------------------------------------------
   localparam int NP = pin_change_pkg::PORTS;
   localparam logic [7:0] B_MASK = LARGE_VARIANT ? pin_change_pkg::PORT_B_MASK
                                                 : pin_change_pkg::ABSENT_MASK;
   localparam logic [7:0] C_MASK = LARGE_VARIANT ? pin_change_pkg::PORT_C_MASK_LARGE
                                                 : pin_change_pkg::PORT_C_MASK_SMALL;
   localparam logic [7:0] PORT_MASK [NP] = '{pin_change_pkg::PORT_A_MASK, B_MASK, C_MASK};

   if (pin_change_pkg::DATA_W != 8 || pin_change_pkg::ADDR_W != 4) begin : g_bad_width
      $error("Register port must be 8 data bits and 4 address bits.");
   end

   // ------------------------------------------------------------
   // Per-port signals
   // ------------------------------------------------------------
   logic [7:0] pins [NP];
   logic [7:0] rise_en [NP];
   logic [7:0] fall_en [NP];
   logic [7:0] flags [NP];
   logic [7:0] hit [NP];
   logic [7:0] rise_ev [NP];
   logic [7:0] fall_ev [NP];

   assign pins[0] = port_a_pin;
   assign pins[1] = port_b_pin;
   assign pins[2] = port_c_pin;

   // ------------------------------------------------------------
   // Port banks
   // ------------------------------------------------------------
   for (genvar p = 0; p < NP; p++) begin : g_port
      port_bank_if bif ();

      assign bif.wr_rise = wr_strobe && (addr == pin_change_pkg::RISE_OFS[p]);
      assign bif.wr_fall = wr_strobe && (addr == pin_change_pkg::FALL_OFS[p]);
      assign bif.wr_flags = wr_strobe && (addr == pin_change_pkg::FLAG_OFS[p]);
      assign bif.wdata = wr_data;
      assign rise_en[p] = bif.rise_en;
      assign fall_en[p] = bif.fall_en;
      assign flags[p] = bif.flags;
      assign hit[p] = bif.hit;

      pin_sync_edge #(
         .W(8)
      ) u_sync (
         .ref_clk(ref_clk),
         .rst(rst),
         .pin_in(pins[p]),
         .rise_ev(rise_ev[p]),
         .fall_ev(fall_ev[p])
      );

      port_change_bank #(
         .MASK(PORT_MASK[p])
      ) u_bank (
         .ref_clk(ref_clk),
         .rst(rst),
         .rise_ev(rise_ev[p]),
         .fall_ev(fall_ev[p]),
         .bus(bif.bank)
      );
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   logic change_irq_enable;
   wire wr_ctrl = wr_strobe && (addr == pin_change_pkg::CTRL_OFS);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         change_irq_enable <= 1'b0; // [R17]
      end else if (wr_ctrl) begin
         change_irq_enable <= wr_data[pin_change_pkg::IRQ_EN_BIT];
      end
   end

   // ------------------------------------------------------------
   // Summary, interrupt and wake
   // ------------------------------------------------------------
   // Flags keep running while the enable is clear; only requests are gated.
   assign change_summary_flag = |(flags[0] | flags[1] | flags[2]); // [R5] [R1]
   assign change_irq = change_irq_enable && change_summary_flag; // [R4] [R1]
   assign wake_req = sleep_mode && change_irq; // [R8] [R9]

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [7:0] next_rd_data;
   wire [7:0] ctrl_view = {7'h00, change_irq_enable};
   wire [7:0] status_view = {6'h00, sleep_mode, change_summary_flag};

   always_comb begin
      next_rd_data = 8'h00;
      case (addr)
         pin_change_pkg::RISE_OFS[0]: next_rd_data = rise_en[0]; // [R10]
         pin_change_pkg::FALL_OFS[0]: next_rd_data = fall_en[0]; // [R11]
         pin_change_pkg::FLAG_OFS[0]: next_rd_data = flags[0]; // [R12]
         pin_change_pkg::RISE_OFS[1]: next_rd_data = rise_en[1]; // [R13]
         pin_change_pkg::FALL_OFS[1]: next_rd_data = fall_en[1]; // [R14]
         pin_change_pkg::FLAG_OFS[1]: next_rd_data = flags[1]; // [R15]
         pin_change_pkg::RISE_OFS[2]: next_rd_data = rise_en[2]; // [R16]
         pin_change_pkg::FALL_OFS[2]: next_rd_data = fall_en[2];
         pin_change_pkg::FLAG_OFS[2]: next_rd_data = flags[2];
         pin_change_pkg::CTRL_OFS: next_rd_data = ctrl_view;
         pin_change_pkg::STATUS_OFS: next_rd_data = status_view;
         default: next_rd_data = 8'h00;
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (rd_strobe) begin
         rd_data <= next_rd_data;
      end else begin
         rd_data <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   wire wr_flag_a = wr_strobe && (addr == pin_change_pkg::FLAG_OFS[0]);
   wire wr_flag_b = wr_strobe && (addr == pin_change_pkg::FLAG_OFS[1]);
   wire wr_flag_c = wr_strobe && (addr == pin_change_pkg::FLAG_OFS[2]);

   flag_set_a: assert property ( // [R4] [R12]
      (hit[0] != 8'h00)
      |=> ((flags[0] & $past(hit[0])) == $past(hit[0]))
   ) else $error("Armed edge on port A did not set its flag.");

   clear_write_a: assert property ( // [R6]
      (wr_flag_a && wr_data == 8'h00 && hit[0] == 8'h00)
      |=> (flags[0] == 8'h00)
   ) else $error("Writing zero did not clear port A flags.");

   set_wins_a: assert property ( // [R6]
      (wr_flag_a && wr_data == 8'h00 && hit[0][0])
      |=> flags[0][0]
   ) else $error("Edge during a clearing write was lost.");

   irq_gated_a: assert property ( // [R1]
      (!change_irq_enable && !wr_ctrl && hit[0][1])
      |=> (flags[0][1] && !change_irq)
   ) else $error("Disabled module either lost a flag or raised a request.");

   irq_raised_a: assert property ( // [R4]
      (change_irq_enable && !wr_ctrl && hit[2] != 8'h00)
      |=> change_irq
   ) else $error("Enabled module did not raise an interrupt request.");

   wake_enabled_a: assert property ( // [R8] [R9]
      (sleep_mode && change_irq_enable && !wr_ctrl && hit[1] != 8'h00)
      |=> (flags[1] != 8'h00) && (!sleep_mode || wake_req)
   ) else $error("Edge in sleep was not recorded or did not wake.");

   no_wake_a: assert property ( // [R8]
      !change_irq_enable |-> !wake_req
   ) else $error("Wake raised with the interrupt enable clear.");

   summary_or_a: assert property ( // [R5]
      (flags[0] == 8'h00 && flags[1] == 8'h00 && flags[2] != 8'h00)
      |-> change_summary_flag
   ) else $error("Summary flag missed a port C flag.");

   unarmed_pin_a: assert property ( // [R2]
      (!flags[0][2] && !wr_flag_a && !rise_en[0][2] && rise_ev[0][2])
      |=> !flags[0][2]
   ) else $error("Unarmed rising edge set a flag.");

   both_dirs_a: assert property ( // [R3]
      (rise_en[0][3] && fall_en[0][3] && (rise_ev[0][3] || fall_ev[0][3]))
      |=> flags[0][3]
   ) else $error("Pin armed both ways missed an edge.");

   reserved_a: assert property ( // [R10] [R11] [R12] [R13] [R14] [R15]
      ((flags[0] | rise_en[0] | fall_en[0]) & ~pin_change_pkg::PORT_A_MASK) == 8'h00
      && ((flags[1] | rise_en[1] | fall_en[1]) & ~B_MASK) == 8'h00
   ) else $error("Unimplemented bit became set.");

   read_port_c_a: assert property ( // [R16]
      (rd_strobe && addr == pin_change_pkg::FLAG_OFS[2])
      |=> (rd_data == ($past(flags[2]) & C_MASK))
   ) else $error("Port C flag read returned the wrong value.");

   sync_latency_a: assert property ( // [R17]
      $rose(g_port[0].u_sync.sync3[4]) && g_port[0].u_sync.sync2[4]
      && g_port[0].u_sync.stable[4] == 1'b0
      && g_port[0].u_sync.state == pin_change_pkg::TRACKING
      |-> rise_ev[0][4]
   ) else $error("Settled rising pin produced no edge pulse.");

   reset_zero_a: assert property ( // [R17]
      $past(rst) |-> (flags[0] == 8'h00 && rise_en[1] == 8'h00 && !change_irq)
   ) else $error("State not cleared by reset.");

   flag_set_b_a: assert property ( // [R15]
      (hit[1] != 8'h00)
      |=> ((flags[1] & $past(hit[1])) == $past(hit[1]))
   ) else $error("Armed edge on port B did not set its flag.");

   flag_set_c_a: assert property ( // [R16]
      (hit[2] != 8'h00)
      |=> ((flags[2] & $past(hit[2])) == $past(hit[2]))
   ) else $error("Armed edge on port C did not set its flag.");

   flag_hold_a: assert property ( // [R12]
      (!wr_flag_a && hit[0] == 8'h00)
      |=> (flags[0] == $past(flags[0]))
   ) else $error("Port A flags changed without an edge or a write.");

   flag_hold_b_a: assert property ( // [R15]
      (!wr_flag_b && hit[1] == 8'h00)
      |=> (flags[1] == $past(flags[1]))
   ) else $error("Port B flags changed without an edge or a write.");

   flag_hold_c_a: assert property ( // [R16]
      (!wr_flag_c && hit[2] == 8'h00)
      |=> (flags[2] == $past(flags[2]))
   ) else $error("Port C flags changed without an edge or a write.");

   clear_write_b_a: assert property ( // [R6]
      (wr_flag_b && wr_data == 8'h00 && hit[1] == 8'h00)
      |=> (flags[1] == 8'h00)
   ) else $error("Writing zero did not clear port B flags.");

   clear_write_c_a: assert property ( // [R6]
      (wr_flag_c && wr_data == 8'h00 && hit[2] == 8'h00)
      |=> (flags[2] == 8'h00)
   ) else $error("Writing zero did not clear port C flags.");

   summary_clear_a: assert property ( // [R5]
      (flags[0] == 8'h00 && flags[1] == 8'h00 && flags[2] == 8'h00)
      |-> !change_summary_flag
   ) else $error("Summary flag set with every pin flag clear.");

   summary_flags_a: assert property ( // [R5]
      (flags[0] != 8'h00)
      |-> change_summary_flag
   ) else $error("Summary flag missed a port A flag.");

   irq_enable_a: assert property ( // [R4]
      (wr_ctrl && wr_data[pin_change_pkg::IRQ_EN_BIT])
      |=> change_irq_enable
   ) else $error("Interrupt enable write did not take.");

   sleep_wake_a: assert property ( // [R8]
      !sleep_mode
      |-> !wake_req
   ) else $error("Wake raised while awake.");

   settle_quiet_a: assert property ( // [R17]
      (g_port[0].u_sync.state == pin_change_pkg::SETTLING)
      |-> (rise_ev[0] == 8'h00 && fall_ev[0] == 8'h00)
   ) else $error("Edge pulse while the synchroniser settles.");

   fall_unarmed_a: assert property ( // [R2]
      (!flags[0][4] && !wr_flag_a && !fall_en[0][4] && fall_ev[0][4])
      |=> !flags[0][4]
   ) else $error("Unarmed falling edge set a flag.");

   read_port_a_a: assert property ( // [R12]
      (rd_strobe && addr == pin_change_pkg::FLAG_OFS[0])
      |=> (rd_data == $past(flags[0]))
   ) else $error("Port A flag read returned the wrong value.");

   // ------------------------------------------------------------
   // Coverage
   // ------------------------------------------------------------
   flag_seen_c: cover property (hit[0] != 8'h00 ##1 change_summary_flag);
   set_wins_c: cover property (wr_flag_a && wr_data == 8'h00 && hit[0] != 8'h00);
   wake_c: cover property (wake_req);
   both_dirs_c: cover property (rise_en[2][0] && fall_en[2][0] && fall_ev[2][0]);
   irq_awake_c: cover property (change_irq && !sleep_mode);

endmodule

// File: verification/pin_stim_model.sv
// Stand-in for the port pads and the processor core around the detector.
// Assumes the bench calls drive from its main sequence on ref_clk.

module pin_stim_model (
   input wire logic ref_clk,
   output logic [7:0] port_a_pin,
   output logic [7:0] port_b_pin,
   output logic [7:0] port_c_pin,
   output logic sleep_mode
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Pad levels
   // ------------------------------------------------------------
   initial begin
      port_a_pin = 8'h00;
      port_b_pin = 8'h00;
      port_c_pin = 8'h00;
      sleep_mode = 1'b0;
   end

   // Levels change just after a rising edge and hold until the next call.
   task automatic drive(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic s);
      @(posedge ref_clk);
      port_a_pin <= a;
      port_b_pin <= b;
      port_c_pin <= c;
      sleep_mode <= s;
   endtask
endmodule

// File: verification/tb_pin_change_interrupt_detector.sv
// Self-checking bench of the pin change detector, large variant, with a small one alongside.
// Assumes the register map and masks of pin_change_pkg and a 200 MHz clock.

module tb_pin_change_interrupt_detector;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wr_data = 8'h00;
   logic wr_strobe = 1'b0;
   logic rd_strobe = 1'b0;
   logic [7:0] rd_data;
   logic [7:0] port_a_pin;
   logic [7:0] port_b_pin;
   logic [7:0] port_c_pin;
   logic sleep_mode;
   logic change_summary_flag;
   logic change_irq;
   logic wake_req;
   logic [7:0] got;
   logic [7:0] seen;
   logic [7:0] rd_data_small;
   logic [7:0] got_small;
   logic [7:0] masks [3];
   logic [7:0] small_masks [3];
   int fails = 0;
   int total_checks = 0;

   pin_change_interrupt_detector #(.LARGE_VARIANT(1'b1)) dut (
      .ref_clk(ref_clk),
      .rst(rst),
      .addr(addr),
      .wr_data(wr_data),
      .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe),
      .rd_data(rd_data),
      .port_a_pin(port_a_pin),
      .port_b_pin(port_b_pin),
      .port_c_pin(port_c_pin),
      .sleep_mode(sleep_mode),
      .change_summary_flag(change_summary_flag),
      .change_irq(change_irq),
      .wake_req(wake_req)
   );

   pin_change_interrupt_detector #(.LARGE_VARIANT(1'b0)) dut_small (
      .ref_clk(ref_clk),
      .rst(rst),
      .addr(addr),
      .wr_data(wr_data),
      .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe),
      .rd_data(rd_data_small),
      .port_a_pin(port_a_pin),
      .port_b_pin(port_b_pin),
      .port_c_pin(port_c_pin),
      .sleep_mode(sleep_mode),
      .change_summary_flag(),
      .change_irq(),
      .wake_req()
   );

   pin_stim_model drv (
      .ref_clk(ref_clk),
      .port_a_pin(port_a_pin),
      .port_b_pin(port_b_pin),
      .port_c_pin(port_c_pin),
      .sleep_mode(sleep_mode)
   );

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------------------
   // Register port and compare tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge ref_clk);
      wr_strobe <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge ref_clk);
      rd_strobe <= 1'b0;
      #1;
      d = rd_data;
      got_small = rd_data_small;
   endtask

   task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] t=%0t reg got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_reg(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] g;
      rd(a, g);
      chk_val(g, e);
   endtask

   task automatic chk_bit(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] t=%0t out got %h exp %h", $time, g, e);
      end
   endtask

   task automatic settle();
      repeat (6) @(posedge ref_clk);
      #1;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #20000;
      fails++;
      print_verdict();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      masks[0] = pin_change_pkg::PORT_A_MASK;
      masks[1] = pin_change_pkg::PORT_B_MASK;
      masks[2] = pin_change_pkg::PORT_C_MASK_LARGE;
      small_masks[0] = pin_change_pkg::PORT_A_MASK;
      small_masks[1] = pin_change_pkg::ABSENT_MASK;
      small_masks[2] = pin_change_pkg::PORT_C_MASK_SMALL;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         chk_reg(i[3:0], 8'h00);
      end
      for (int p = 0; p < 3; p++) begin
         wr(pin_change_pkg::RISE_OFS[p], 8'hff);
         wr(pin_change_pkg::FALL_OFS[p], 8'hff);
         wr(pin_change_pkg::FLAG_OFS[p], 8'hff);
         chk_reg(pin_change_pkg::RISE_OFS[p], masks[p]);
         chk_val(got_small, small_masks[p]);
         chk_reg(pin_change_pkg::FALL_OFS[p], masks[p]);
         chk_reg(pin_change_pkg::FLAG_OFS[p], masks[p]);
         chk_val(got_small, small_masks[p]);
         chk_bit(change_summary_flag, 1'b1);
         wr(pin_change_pkg::RISE_OFS[p], 8'h00);
         wr(pin_change_pkg::FALL_OFS[p], 8'h00);
         wr(pin_change_pkg::FLAG_OFS[p], 8'h00);
      end
      wr(4'hf, 8'hff);
      chk_reg(4'hf, 8'h00);
      chk_bit(change_summary_flag, 1'b0);
      // Bit 0 rising only, bit 1 falling only, bit 2 both, bits 5..3 unarmed.
      wr(pin_change_pkg::RISE_OFS[0], 8'h05);
      wr(pin_change_pkg::FALL_OFS[0], 8'h06);
      drv.drive(8'h3f, 8'h0f, 8'h00, 1'b0);
      settle();
      chk_reg(pin_change_pkg::FLAG_OFS[0], 8'h05);
      chk_reg(pin_change_pkg::FLAG_OFS[1], 8'h00);
      chk_bit(change_summary_flag, 1'b1);
      chk_bit(change_irq, 1'b0);
      drv.drive(8'h00, 8'h00, 8'h00, 1'b0);
      settle();
      chk_reg(pin_change_pkg::FLAG_OFS[0], 8'h07);
      wr(pin_change_pkg::CTRL_OFS, 8'h01);
      #1;
      chk_bit(change_irq, 1'b1);
      drv.drive(8'h00, 8'h00, 8'h00, 1'b1);
      #1;
      chk_bit(wake_req, 1'b1);
      chk_reg(pin_change_pkg::STATUS_OFS, 8'h03);
      // Masked clear of the bits seen set.
      rd(pin_change_pkg::FLAG_OFS[0], got);
      got = got ^ 8'hff;
      rd(pin_change_pkg::FLAG_OFS[0], seen);
      wr(pin_change_pkg::FLAG_OFS[0], seen & got);
      chk_reg(pin_change_pkg::FLAG_OFS[0], 8'h00);
      chk_bit(change_summary_flag, 1'b0);
      chk_bit(wake_req, 1'b0);
      // A clearing write lands on the edge that sets the flag, during sleep.
      drv.drive(8'h01, 8'h00, 8'h00, 1'b1);
      repeat (2) @(posedge ref_clk);
      wr(pin_change_pkg::FLAG_OFS[0], 8'h00);
      #1;
      chk_bit(wake_req, 1'b1);
      chk_reg(pin_change_pkg::FLAG_OFS[0], 8'h01);
      wr(pin_change_pkg::CTRL_OFS, 8'h00);
      #1;
      chk_bit(wake_req, 1'b0);
      chk_bit(change_irq, 1'b0);
      chk_bit(change_summary_flag, 1'b1);
      wr(pin_change_pkg::FLAG_OFS[0], 8'h00);
      // Port B rising and port C falling.
      wr(pin_change_pkg::RISE_OFS[1], 8'hf0);
      wr(pin_change_pkg::FALL_OFS[2], 8'hff);
      drv.drive(8'h01, 8'hff, 8'hff, 1'b0);
      settle();
      chk_reg(pin_change_pkg::FLAG_OFS[1], 8'hf0);
      chk_reg(pin_change_pkg::FLAG_OFS[2], 8'h00);
      chk_reg(pin_change_pkg::FLAG_OFS[0], 8'h00);
      drv.drive(8'h01, 8'h00, 8'h00, 1'b0);
      settle();
      chk_reg(pin_change_pkg::FLAG_OFS[2], 8'hff);
      chk_reg(pin_change_pkg::STATUS_OFS, 8'h01);
      print_verdict();
   end
endmodule
